// ### smbus_cfg_params.svh
// Constants of the SMBus configuration port: register indexes, reset values, address
// Overview of operation
// - The block only answers as an SMBus target, never drives the clock, and serves block write and read.
// - Each transfer opens with a 7-bit target address and a direction bit, zero to write, one to read.
// - The address has 1101 in its upper four bits and the strap value, caught after reset, in the low three.
// - A block read sets index N, then after a repeated start returns the count byte and bytes from N on.
// - A stop after any whole byte ends the transfer early and keeps every byte completed before it.
// - Index zero holds one read-write enable bit per output, all one after reset, a one leaving the pin in control.
// - A zero enable bit overrides the output's pin and forces the pair to the stop state kept in index eleven.
`ifndef SMBUS_CFG_PARAMS_SVH
`define SMBUS_CFG_PARAMS_SVH

`define ADDR_FIXED 4'hd
`define OE_BYTE_IDX 8'h00
`define COUNT_IDX 8'h07
`define STOP_STATE_IDX 8'h0b
`define OE_RESET 8'hff
`define COUNT_RESET 8'h08
`define STOP_STATE_RESET 8'h00
`define CFG_RESET 8'h00
`define STOP_FIELD_MSB 1
`define STOP_FIELD_LSB 0
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT 4'h9
`define STRAP_SETTLE 2'h2

`endif

// ### smbus_cfg_pkg.sv
// Types shared by the SMBus configuration port
`default_nettype none
package smbus_cfg_pkg;

    // Gray along idle, address, index, count, write; read hangs off write
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_INDEX = 3'h3,
        ST_COUNT = 3'h2,
        ST_WRITE = 3'h6,
        ST_READ  = 3'h7
    } xfer_state_t;

    // Synchronised bus lines and their events
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } line_evt_t;

    // Per-output run enables and the common stop state
    typedef struct packed {
        logic [7:0] run;
        logic [1:0] stop_state;
    } out_ctrl_t;

endpackage
`default_nettype wire

// ### smbus_line_sync.sv
// Two-flop synchroniser and edge, start and stop detection for SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module smbus_line_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output var smbus_cfg_pkg::line_evt_t evt_o
);
    import smbus_cfg_pkg::*;

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    // Idle bus is high on both lines, so reset to ones to avoid a false start
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
            prev_q <= 2'h3;
        end else if (ce_i) begin
            meta_q <= {scl_i, sda_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Events look only at the second stage and its delayed copy
    always_comb begin
        evt_o.scl = sync_q[1];
        evt_o.sda = sync_q[0];
        evt_o.scl_rise = sync_q[1] & ~prev_q[1];
        evt_o.scl_fall = ~sync_q[1] & prev_q[1];
        evt_o.start = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
        evt_o.stop = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
    end
endmodule
`default_nettype wire

// ### smbus_cfg_slave.sv
// SMBus target with indexed block access to configuration bytes and output enable control
`timescale 1ns/1ps
`default_nettype none
`include "smbus_cfg_params.svh"
module smbus_cfg_slave #(
    parameter int unsigned REG_COUNT = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [2:0] address_strap_pin_i,
    input wire logic [7:0] out_enable_pin_n_i,
    output var smbus_cfg_pkg::out_ctrl_t out_ctrl_o
);
    import smbus_cfg_pkg::*;

    line_evt_t evt;
    xfer_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic [7:0] remain_q;
    logic rnw_q;
    logic sda_oe_q;
    logic [7:0] cfg_q [REG_COUNT];
    logic [2:0] strap_meta_q;
    logic [2:0] strap_sync_q;
    logic [2:0] own_addr_q;
    logic [1:0] strap_age_q;
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    out_ctrl_t out_q;
    logic addr_match;
    logic rx_byte;
    logic ack_end;
    logic ack_bit_rise;
    logic wr_hit;

    smbus_line_sync i_smbus_line_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .evt_o(evt)
    );

    // Indexes past the table read as zero rather than wrapping
    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx < 8'(REG_COUNT)) begin
            val = cfg_q[int'(idx)];
        end
        return val;
    endfunction

    // Byte-slot decode; counter counts SCL rises, nine per byte slot
    assign addr_match = (shift_q[7:1] == {`ADDR_FIXED, own_addr_q});
    assign rx_byte = ce_i & evt.scl_fall & (cnt_q == `BITS_PER_BYTE);
    assign ack_end = ce_i & evt.scl_fall & (cnt_q == `ACK_SLOT);
    assign ack_bit_rise = ce_i & evt.scl_rise & (cnt_q == `BITS_PER_BYTE);
    assign wr_hit = rx_byte && (state_q == ST_WRITE) && (remain_q != 8'h00)
                    && (ptr_q < 8'(REG_COUNT)) && (ptr_q != `COUNT_IDX);

    // Open drain: the data output is only ever a low, the enable does the work
    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_oe_q;
    assign out_ctrl_o = out_q;

    // Strap is caught once, after the synchroniser has filled
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_meta_q <= 3'h0;
            strap_sync_q <= 3'h0;
            strap_age_q <= 2'h0;
            own_addr_q <= 3'h0;
        end else if (ce_i) begin
            strap_meta_q <= address_strap_pin_i;
            strap_sync_q <= strap_meta_q;
            if (strap_age_q != 2'h3) begin
                strap_age_q <= strap_age_q + 2'h1;
            end
            if (strap_age_q == `STRAP_SETTLE) begin
                own_addr_q <= strap_sync_q;
            end
        end
    end

    // Transfer state; start and stop override any byte in progress
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (evt.start) begin
                state_q <= ST_ADDR;
                cnt_q <= 4'h0;
            end else if (evt.stop) begin
                state_q <= ST_IDLE;
                cnt_q <= 4'h0;
            end else if (state_q != ST_IDLE) begin
                if (evt.scl_rise && cnt_q != `ACK_SLOT) begin
                    cnt_q <= cnt_q + 4'h1;
                end
                if (rx_byte && state_q == ST_ADDR && !addr_match) begin
                    state_q <= ST_IDLE;
                end
                if (ack_bit_rise && state_q == ST_READ && evt.sda) begin
                    state_q <= ST_IDLE;
                end
                if (evt.scl_fall && cnt_q == `ACK_SLOT) begin
                    cnt_q <= 4'h0;
                    unique case (state_q)
                        ST_ADDR: state_q <= rnw_q ? ST_READ : ST_INDEX;
                        ST_INDEX: state_q <= ST_COUNT;
                        ST_COUNT: state_q <= ST_WRITE;
                        ST_WRITE: state_q <= ST_WRITE;
                        ST_READ: state_q <= ST_READ;
                        default: state_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // Receive shifter, MSB first, sampled on SCL rise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= 8'h00;
            rnw_q <= 1'b0;
        end else if (ce_i) begin
            if (evt.scl_rise && cnt_q < `BITS_PER_BYTE) begin
                shift_q <= {shift_q[6:0], evt.sda};
            end
            if (rx_byte && state_q == ST_ADDR) begin
                rnw_q <= shift_q[0];
            end
        end
    end

    // Index pointer and remaining write count; pointer survives the repeated start
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_q <= 8'h00;
            remain_q <= 8'h00;
        end else if (ce_i) begin
            if (rx_byte && state_q == ST_INDEX) begin
                ptr_q <= shift_q;
            end else if (rx_byte && state_q == ST_COUNT) begin
                remain_q <= shift_q;
            end else if (rx_byte && state_q == ST_WRITE && remain_q != 8'h00) begin
                ptr_q <= ptr_q + 8'h01;
                remain_q <= remain_q - 8'h01;
            end else if (ack_end && state_q == ST_READ) begin
                ptr_q <= ptr_q + 8'h01;
            end
        end
    end

    // SDA drive: ack on ninth clock, read bits change on SCL fall
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_q <= 1'b1;
            tx_q <= 8'hff;
        end else if (ce_i) begin
            if (evt.start || evt.stop) begin
                sda_oe_q <= 1'b1;
            end else if (rx_byte) begin
                unique case (state_q)
                    ST_ADDR: sda_oe_q <= !addr_match;
                    ST_INDEX, ST_COUNT, ST_WRITE: sda_oe_q <= 1'b0;
                    ST_READ: sda_oe_q <= 1'b1;
                    default: sda_oe_q <= 1'b1;
                endcase
            end else if (ack_end && state_q == ST_ADDR && rnw_q) begin
                tx_q <= read_byte(`COUNT_IDX);
                sda_oe_q <= read_byte(`COUNT_IDX) >> 7 != 8'h00;
            end else if (ack_end && state_q == ST_READ) begin
                tx_q <= read_byte(ptr_q);
                sda_oe_q <= read_byte(ptr_q) >> 7 != 8'h00;
            end else if (ack_end) begin
                sda_oe_q <= 1'b1;
            end else if (evt.scl_fall && state_q == ST_READ && cnt_q != 4'h0
                         && cnt_q < `BITS_PER_BYTE) begin
                tx_q <= {tx_q[6:0], 1'b1};
                sda_oe_q <= tx_q[6];
            end
        end
    end

    // Configuration bytes; the count byte is read-only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                if (i == int'(`OE_BYTE_IDX)) begin
                    cfg_q[i] <= `OE_RESET;
                end else if (i == int'(`COUNT_IDX)) begin
                    cfg_q[i] <= `COUNT_RESET;
                end else if (i == int'(`STOP_STATE_IDX)) begin
                    cfg_q[i] <= `STOP_STATE_RESET;
                end else begin
                    cfg_q[i] <= `CFG_RESET;
                end
            end
        end else if (ce_i && wr_hit) begin
            cfg_q[int'(ptr_q)] <= shift_q;
        end
    end

    // Output control; enable pins are asynchronous so they are synchronised first
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= 8'hff;
            pin_sync_q <= 8'hff;
            out_q <= '0;
        end else if (ce_i) begin
            pin_meta_q <= out_enable_pin_n_i;
            pin_sync_q <= pin_meta_q;
            out_q.run <= cfg_q[int'(`OE_BYTE_IDX)] & ~pin_sync_q;
            out_q.stop_state <= cfg_q[int'(`STOP_STATE_IDX)][`STOP_FIELD_MSB:`STOP_FIELD_LSB];
        end
    end

    a_addr_nack: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (rx_byte && state_q == ST_ADDR && !addr_match) |=> (state_q == ST_IDLE && sda_oe_q))
        else $error("mismatched address was acknowledged");

    a_addr_ack: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (rx_byte && state_q == ST_ADDR && addr_match) |=> (!sda_oe_q && rnw_q == $past(shift_q[0])))
        else $error("own address not acknowledged");

    a_dir_select: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ack_end && state_q == ST_ADDR) |=> (state_q == ($past(rnw_q) ? ST_READ : ST_INDEX)))
        else $error("direction bit chose the wrong path");

    a_write_store: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (rx_byte && state_q == ST_WRITE && remain_q != 8'h00 && ptr_q == `OE_BYTE_IDX)
        |=> (cfg_q[0] == $past(shift_q) && !sda_oe_q))
        else $error("written byte not stored or not acknowledged");

    a_read_count: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ack_end && state_q == ST_ADDR && rnw_q)
        |=> (state_q == ST_READ && tx_q == cfg_q[int'(`COUNT_IDX)] && sda_oe_q == tx_q[7]))
        else $error("block read did not open with the count byte");

    a_read_nack: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ack_bit_rise && state_q == ST_READ && evt.sda) |=> (state_q == ST_IDLE ##1 sda_oe_q))
        else $error("read continued after host NACK");

    a_stop_ends: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && evt.stop && !evt.start) |=> (state_q == ST_IDLE && sda_oe_q && cnt_q == 4'h0))
        else $error("stop did not end the transfer");

    a_idle_quiet: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_IDLE && $past(state_q) == ST_IDLE) |-> sda_oe_q)
        else $error("data line driven while idle");

    a_forced_stop: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && !cfg_q[0][0])[*2] |-> (!out_q.run[0] && out_q.stop_state == $past(cfg_q[11][1:0])))
        else $error("disabled output not forced to stop state");

    a_pin_control: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && cfg_q[0][0] && !pin_sync_q[0]) |=> out_q.run[0])
        else $error("enabled output ignored its pin");
endmodule
`default_nettype wire

// ### smbus_host_model.sv
// Behavioural SMBus host that runs block transfers on the serial pins
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire logic core_clk_i,
    input wire logic line_i,
    output logic scl_o,
    output logic sda_o,
    output logic result_stb_o,
    output logic [7:0] result_o
);
    int hp = 8;

    // Pins start released, the pull-up holds the wire high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        result_stb_o = 1'b0;
        result_o = 8'h00;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // SDA moves only while SCL is low, so no false start or stop
    task automatic put_bit(input logic b);
        sda_o <= b;
        wt(hp);
        scl_o <= 1'b1;
        wt(hp);
        scl_o <= 1'b0;
        wt(hp / 2);
    endtask

    // Sample mid-high, well after the target's data has settled
    task automatic get_bit(output logic b);
        sda_o <= 1'b1;
        wt(hp);
        scl_o <= 1'b1;
        wt(hp / 2);
        b = line_i;
        wt(hp / 2);
        scl_o <= 1'b0;
        wt(hp / 2);
    endtask

    // Two edges per report so the strobe never toggles twice in one step
    task automatic report(input logic [7:0] v);
        result_o <= v;
        result_stb_o <= 1'b1;
        wt(1);
        result_stb_o <= 1'b0;
        wt(1);
    endtask

    // Start or repeated start, entered with SCL low or idle
    task automatic start_c();
        sda_o <= 1'b1;
        wt(hp);
        scl_o <= 1'b1;
        wt(hp);
        sda_o <= 1'b0;
        wt(hp);
        scl_o <= 1'b0;
        wt(hp / 2);
    endtask

    task automatic stop_c();
        sda_o <= 1'b0;
        wt(hp);
        scl_o <= 1'b1;
        wt(hp);
        sda_o <= 1'b1;
        wt(hp);
    endtask

    // Byte out MSB first, then report the acknowledge as a one
    task automatic send_byte(input logic [7:0] v);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(ack);
        report({7'h0, ~ack});
    endtask

    // Byte in, then ACK or, on the last byte, NACK
    task automatic read_byte(input logic last);
        logic [7:0] v;
        logic b;
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            get_bit(b);
            v = {v[6:0], b};
        end
        put_bit(last);
        report(v);
    endtask
endmodule
`default_nettype wire

// ### smbus_config_slave_output_enable_tb.sv
// Self-checking bench for the SMBus configuration port
`timescale 1ns/1ps
`default_nettype none
module smbus_config_slave_output_enable_tb;
    import smbus_cfg_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic scl, host_sda, sda_line, sda_o, sda_oe_n_o, result_stb;
    logic [7:0] result;
    logic [2:0] strap = 3'h0;
    logic [7:0] pin_n = 8'h00;
    logic [6:0] own;
    logic [7:0] v, a, b;
    logic [7:0] exp_q[$];
    out_ctrl_t out_ctrl_o;
    int n_fail = 0;
    int check_count = 0;

    // Open-drain wire: target pulls low while its enable is low
    assign sda_line = host_sda & (sda_oe_n_o ? 1'b1 : sda_o);
    assign own = {4'hd, strap};

    smbus_cfg_slave #(.REG_COUNT(12)) i_smbus_cfg_slave (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .address_strap_pin_i(strap),
        .out_enable_pin_n_i(pin_n), .out_ctrl_o(out_ctrl_o));

    smbus_host_model i_smbus_host_model (
        .core_clk_i(core_clk_i), .line_i(sda_line), .scl_o(scl), .sda_o(host_sda),
        .result_stb_o(result_stb), .result_o(result));

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] expv);
        check_count++;
        if (seen !== expv) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic note(input logic [7:0] e);
        exp_q.push_back(e);
    endtask

    // Block write; a foreign address ends after its unanswered byte
    task automatic wr(input logic [6:0] adr, input logic [7:0] idx, cnt, d0, d1, input int n);
        i_smbus_host_model.start_c();
        note({7'h0, adr == own});
        i_smbus_host_model.send_byte({adr, 1'b0});
        if (adr == own) begin
            note(8'h01);
            i_smbus_host_model.send_byte(idx);
            note(8'h01);
            i_smbus_host_model.send_byte(cnt);
            for (int i = 0; i < n; i++) begin
                note(8'h01);
                i_smbus_host_model.send_byte(i ? d1 : d0);
            end
        end
        i_smbus_host_model.stop_c();
    endtask

    // Block read of n bytes after the count byte
    task automatic rd(input logic [7:0] idx, e0, e1, input int n);
        i_smbus_host_model.start_c();
        note(8'h01);
        i_smbus_host_model.send_byte({own, 1'b0});
        note(8'h01);
        i_smbus_host_model.send_byte(idx);
        i_smbus_host_model.start_c();
        note(8'h01);
        i_smbus_host_model.send_byte({own, 1'b1});
        note(8'h08);
        i_smbus_host_model.read_byte(n == 0);
        for (int i = 0; i < n; i++) begin
            note(i ? e1 : e0);
            i_smbus_host_model.read_byte(i == n - 1);
        end
        i_smbus_host_model.stop_c();
    endtask

    // Output control after the pin synchroniser has settled
    task automatic ctrl(input logic [7:0] en, input logic [1:0] st);
        repeat (8) @(posedge core_clk_i);
        check("out_ctrl", out_ctrl_o, {en & ~pin_n, st});
    endtask

    // Free-running core clock
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Each reported bus byte is matched against the oldest note
    always @(posedge core_clk_i) begin
        if (result_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected result", {2'h0, result}, 10'h3ff);
            end else begin
                check("bus result", {2'h0, result}, {2'h0, exp_q.pop_front()});
            end
        end
    end

    // Watchdog so a stuck transfer still reaches the verdict
    initial begin
        repeat (90000) @(posedge core_clk_i);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        void'($urandom(40));
        @(posedge core_clk_i);
        strap <= 3'($urandom);
        pin_n <= 8'($urandom) & 8'hfe; // Output 0 starts pin-enabled
        repeat (15) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        ctrl(8'hff, 2'h0);
        wr(own ^ 7'h01, 8'h00, 8'h01, 8'h00, 8'h00, 1);
        wr(own ^ 7'h08, 8'h00, 8'h01, 8'h00, 8'h00, 1);
        rd(8'h00, 8'hff, 8'h00, 2);
        v = 8'($urandom) & 8'hfe; // Output 0 later forced to its stop state
        a = 8'($urandom);
        b = 8'($urandom);
        wr(own, 8'h00, 8'h03, v, a, 1);
        i_smbus_host_model.hp = 12;
        rd(8'h00, v, 8'h00, 2);
        wr(own, 8'h0a, 8'h02, a, b, 2);
        rd(8'h0a, a, b, 2);
        // Second data byte lies beyond the count, so index eleven keeps b
        wr(own, 8'h0a, 8'h01, b, a, 2);
        rd(8'h0a, b, b, 2);
        ctrl(v, b[1:0]);
        pin_n <= ~pin_n;
        ctrl(v, b[1:0]);
        // Clock enable low must freeze the outputs while the pins move
        ce <= 1'b0;
        pin_n <= ~pin_n;
        repeat (8) @(posedge core_clk_i);
        check("frozen out_ctrl", out_ctrl_o, {v & pin_n, b[1:0]});
        ce <= 1'b1;
        ctrl(v, b[1:0]);
        repeat (20) @(posedge core_clk_i);
        check("pending results", 10'(exp_q.size()), 10'h000);
        end_sim();
    end
endmodule
`default_nettype wire
